//--- ima_pkg.sv
/*
 Shared constants and types of the indirect management engine:
 register offsets, slot field layout, frame codes and MDC timing.
 Assumes a 125 MHz system clock and an APB register bus.
*/
package ima_pkg;
    // ========================================================
    // Register map
    localparam int SLOT_NUM = 8;
    localparam logic [7:0] OFF_SLOT_END = 8'h20;
    localparam logic [7:0] OFF_CFG = 8'h20;
    localparam logic [7:0] OFF_LINK = 8'h24;
    localparam logic [7:0] OFF_GRP = 8'h28;
    localparam logic [31:0] SLOT_RST = 32'h8000_0000;
    // ========================================================
    // Slot and register field layout
    localparam int SL_DATA_LSB = 0;
    localparam int SL_DEV_LSB = 16;
    localparam int SL_PRT_LSB = 21;
    localparam int SL_OP_LSB = 26;
    localparam int SL_ST_LSB = 28;
    localparam int SL_DONE = 31;
    localparam int CFG_SPEED = 0;
    localparam int CFG_PDOWN = 1;
    localparam int LNK_UP = 0;
    localparam int LNK_PAGE = 1;
    localparam int GRP_KNOWN = 0;
    localparam int GRP_VENDOR = 1;
    // ========================================================
    // Frame codes
    localparam logic [1:0] OP_ADDR = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_INCRD = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;
    localparam logic [1:0] ST_C45 = 2'h0;
    localparam logic [1:0] ST_C22 = 2'h1;
    localparam logic [1:0] C22_WR = 2'h1;
    localparam logic [1:0] C22_RD = 2'h2;
    localparam logic [1:0] TA_WR = 2'h2;
    localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;
    localparam logic [4:0] MMD_PMA = 5'h01;
    localparam logic [4:0] MMD_PCS = 5'h03;
    localparam logic [4:0] MMD_AN = 5'h07;
    localparam logic [4:0] MMD_VEND1 = 5'h1E;
    localparam int VENDOR_BIT = 15;
    localparam logic [6:0] TA_IDX = 7'h2E;
    localparam logic [6:0] DATA_IDX = 7'h30;
    localparam logic [6:0] FRAME_LAST = 7'h3F;
    // ========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MDC_SLOW_NS = 400;
    localparam int MDC_FAST_NS = 240;
    localparam logic [5:0] HALF_SLOW = 6'(MDC_SLOW_NS / (2 * CLK_PERIOD_NS));
    localparam logic [5:0] HALF_FAST = 6'(MDC_FAST_NS / (2 * CLK_PERIOD_NS));
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [1:0] {ENG_SCAN, ENG_LAUNCH, ENG_WAIT} ima_eng_t;

    function automatic logic mmdKnown(input logic [4:0] dev);
        return dev == MMD_PMA || dev == MMD_PCS || dev == MMD_AN ||
            dev == MMD_VEND1;
    endfunction
endpackage

//--- ima_mdc_gen.sv
/*
 MDC divider: derives the management clock from mclk and gives
 one-cycle enables at its rising and falling edges.
 Assumes mclk at 125 MHz; the speed select comes from a register.
*/
`timescale 1ns/100ps
module ima_mdc_gen import ima_pkg::*; (
    input wire logic mclk, // system clock
    input wire logic reset_n, // sync reset, active low
    input wire logic fastSel, // 1 selects the faster MDC
    output logic mdc, // management clock level
    output logic riseEn, // pulse with MDC rising
    output logic fallEn // pulse with MDC falling
);
    typedef struct packed {
        logic [5:0] cnt;
        logic mdc;
        logic rise;
        logic fall;
    } ima_mdc_st_t;

    ima_mdc_st_t s_ff, nxt_s;
    logic [5:0] half;

    always_comb begin
        half = fastSel ? HALF_FAST : HALF_SLOW;
        nxt_s = s_ff;
        nxt_s.rise = 1'b0;
        nxt_s.fall = 1'b0;
        // Compare with >= so a speed change mid-phase cannot stall
        if (s_ff.cnt >= 6'(half - 6'h1)) begin
            nxt_s.cnt = 6'h0;
            nxt_s.mdc = ~s_ff.mdc;
            nxt_s.rise = ~s_ff.mdc;
            nxt_s.fall = s_ff.mdc;
        end else begin
            nxt_s.cnt = 6'(s_ff.cnt + 6'h1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign mdc = s_ff.mdc;
    assign riseEn = s_ff.rise;
    assign fallEn = s_ff.fall;
endmodule

//--- ima_mdio_shift.sv
/*
 MDIO frame shifter: sends one 64-bit management frame, releases
 the line from turnaround on reads and captures 16 data bits.
 Assumes mdioIn is already synchronised to mclk.
*/
`timescale 1ns/100ps
module ima_mdio_shift import ima_pkg::*; (
    input wire logic mclk, // system clock
    input wire logic reset_n, // sync reset, active low
    input wire logic riseEn, // MDC rising enable
    input wire logic fallEn, // MDC falling enable
    input wire logic start, // level: frame waiting
    input wire logic [63:0] frame, // frame bits, MSB first
    input wire logic turnRead, // 1 for a read frame
    input wire logic mdioIn, // synchronised line level
    output logic busy, // frame in progress
    output logic done, // pulse at end of frame
    output logic [15:0] rdData, // captured read data
    output logic mdioOut, // line drive value
    output logic mdioOe // 1 while driving the line
);
    typedef struct packed {
        logic active;
        logic done;
        logic oe;
        logic out;
        logic isRead;
        logic [6:0] cnt;
        logic [63:0] sh;
        logic [15:0] rd;
    } ima_shf_st_t;

    ima_shf_st_t s_ff, nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        if (!s_ff.active) begin
            // Load on a falling edge so bit 0 has a full setup phase
            if (start && fallEn) begin
                nxt_s.active = 1'b1;
                nxt_s.sh = frame;
                nxt_s.out = frame[63];
                nxt_s.oe = 1'b1;
                nxt_s.cnt = 7'h0;
                nxt_s.isRead = turnRead;
            end
        end else if (riseEn) begin
            if (s_ff.isRead && s_ff.cnt >= DATA_IDX) begin
                nxt_s.rd = {s_ff.rd[14:0], mdioIn};
            end
            if (s_ff.cnt == FRAME_LAST) begin
                nxt_s.active = 1'b0;
                nxt_s.oe = 1'b0;
                nxt_s.done = 1'b1;
            end else begin
                nxt_s.cnt = 7'(s_ff.cnt + 7'h1);
            end
        end else if (fallEn) begin
            nxt_s.sh = {s_ff.sh[62:0], 1'b0};
            nxt_s.out = s_ff.sh[62];
            nxt_s.oe = !(s_ff.isRead && s_ff.cnt >= TA_IDX);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign busy = s_ff.active;
    assign done = s_ff.done;
    assign rdData = s_ff.rd;
    assign mdioOut = s_ff.out;
    assign mdioOe = s_ff.oe;
endmodule

//--- ima_mdio_engine.sv
/*
 Indirect management engine: eight APB-visible access slots, a
 round-robin MDIO master, the configuration word, a latch-low link
 status register and strap capture for the power-down default.
 Assumes an APB master on mclk and an MDIO PHY on the mdc/mdio pins;
 link, page and strap pins are asynchronous.

*/
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
module ima_mdio_engine import ima_pkg::*; (
    input wire logic mclk, // system clock, 125 MHz
    input wire logic reset_n, // sync reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, 1 write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    output logic mdc, // management clock
    input wire logic mdioIn, // MDIO line level
    output logic mdioOut, // MDIO drive value
    output logic mdioOe, // MDIO output enable
    input wire logic linkUpPin, // live link state
    input wire logic pageRxPin, // page received indication
    input wire logic strapPowerDown, // power-down strap
    output logic phyPowerDown // software power-down state
);
    typedef struct packed {
        logic [SLOT_NUM-1:0][31:0] slot;
        logic speedSel;
        logic pwrDown;
        logic [2:0] cur;
        ima_eng_t eng;
        logic linkLatch;
        logic grpKnown;
        logic grpVendor;
        logic [31:0] rdata;
        logic [1:0] strapCnt;
        logic strapDone;
        logic [1:0] mdioSync;
        logic [1:0] linkSync;
        logic [1:0] pageSync;
        logic [1:0] strapSync;
    } ima_top_st_t;

    ima_top_st_t s_ff, nxt_s;
    logic riseEn;
    logic fallEn;
    logic shBusy;
    logic shDone;
    logic [15:0] shRd;
    logic [31:0] curSlot;
    logic [63:0] curFrame;
    logic setup;
    logic access;
    logic hitSlot;
    logic hit;
    logic linkLive;
    logic linkShown;
    logic shStart;
    logic [1:0] curSt;
    logic [1:0] curOp;
    logic [4:0] curDev;
    logic curRead;

    // ========================================================
    // Frame assembly
    function automatic logic [63:0] buildFrame(input logic [31:0] w);
        logic [1:0] st;
        logic [1:0] op;
        st = w[SL_ST_LSB +: 2];
        op = w[SL_OP_LSB +: 2];
        if (st == ST_C22) begin
            // Register address rides in the device field
            op = op[1] ? C22_RD : C22_WR;
        end
        // Clause 45 opcodes equal the slot encoding
        return {
            PREAMBLE,
            st,
            op,
            w[SL_PRT_LSB +: 5],
            w[SL_DEV_LSB +: 5],
            TA_WR,
            w[SL_DATA_LSB +: 16]
        };
    endfunction

    // ========================================================
    // Address decode and slot pointer
    function automatic logic slotHit(input logic [7:0] a);
        return a < OFF_SLOT_END && a[1:0] == 2'h0;
    endfunction

    function automatic logic [2:0] slotIdx(input logic [7:0] a);
        return a[4:2];
    endfunction

    // Pointer wraps from the last slot back to slot 0
    function automatic logic [2:0] nextSlot(input logic [2:0] c);
        return 3'(c + 3'h1);
    endfunction

    // Link word: the latch hides a live link until the word is read or pwrDown is set
    function automatic logic [31:0] linkWord(input logic up,
            input logic page);
        logic [31:0] w;
        w = '0;
        w[LNK_UP] = up;
        w[LNK_PAGE] = page;
        return w;
    endfunction

    function automatic logic [31:0] cfgWord(input logic fast,
            input logic pdown);
        logic [31:0] w;
        w = '0;
        w[CFG_SPEED] = fast;
        w[CFG_PDOWN] = pdown;
        return w;
    endfunction

    function automatic logic [31:0] grpWord(input logic known,
            input logic vendor);
        logic [31:0] w;
        w = '0;
        w[GRP_KNOWN] = known;
        w[GRP_VENDOR] = vendor;
        return w;
    endfunction

    assign curSlot = s_ff.slot[s_ff.cur];
    assign curFrame = buildFrame(curSlot);
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hitSlot = slotHit(paddr);
    assign hit = hitSlot || paddr == OFF_CFG || paddr == OFF_LINK ||
        paddr == OFF_GRP;
    assign linkLive = s_ff.linkSync[1];
    assign linkShown = linkLive && !s_ff.linkLatch;
    // Level request: the shifter waits for its own MDC fall
    assign shStart = s_ff.eng == ENG_LAUNCH;

    // ========================================================
    // Current slot fields
    assign curSt = curSlot[SL_ST_LSB +: 2];
    assign curOp = curSlot[SL_OP_LSB +: 2];
    assign curDev = curSlot[SL_DEV_LSB +: 5];
    // Op codes 2 and 3 both return data
    assign curRead = curOp[1];

    // ========================================================
    // Next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.mdioSync = {s_ff.mdioSync[0], mdioIn};
        nxt_s.linkSync = {s_ff.linkSync[0], linkUpPin};
        nxt_s.pageSync = {s_ff.pageSync[0], pageRxPin};
        nxt_s.strapSync = {s_ff.strapSync[0], strapPowerDown};

        // Strap wait covers the two synchroniser stages
        if (!s_ff.strapDone) begin
            if (s_ff.strapCnt == STRAP_WAIT) begin
                nxt_s.strapDone = 1'b1;
                nxt_s.pwrDown = s_ff.strapSync[1];
            end else begin
                nxt_s.strapCnt = 2'(s_ff.strapCnt + 2'h1);
            end
        end

        // Read data is captured in setup so prdata comes from a flop
        if (setup) begin
            nxt_s.rdata = '0;
            if (hitSlot) begin
                nxt_s.rdata = s_ff.slot[slotIdx(paddr)];
            end else if (paddr == OFF_CFG) begin
                nxt_s.rdata = cfgWord(s_ff.speedSel, s_ff.pwrDown);
            end else if (paddr == OFF_LINK) begin
                nxt_s.rdata = linkWord(linkShown, s_ff.pageSync[1]);
            end else if (paddr == OFF_GRP) begin
                nxt_s.rdata = grpWord(s_ff.grpKnown, s_ff.grpVendor);
            end
        end

        if (access && pwrite) begin
            if (hitSlot) begin
                nxt_s.slot[slotIdx(paddr)] = pwdata;
            end else if (paddr == OFF_CFG) begin
                nxt_s.speedSel = pwdata[CFG_SPEED];
                nxt_s.pwrDown = pwdata[CFG_PDOWN];
            end
        end

        // Whole-address read clears latch; a new drop still wins unless pwrDown is set
        if (access && !pwrite && paddr == OFF_LINK) begin
            nxt_s.linkLatch = 1'b0;
        end
        if (s_ff.pwrDown) begin
            nxt_s.linkLatch = 1'b0;
        end else if (!linkLive) begin
            nxt_s.linkLatch = 1'b1;
        end

        // Engine updates follow host writes so completion wins
        unique case (s_ff.eng)
            ENG_SCAN: begin
                if (!curSlot[SL_DONE]) begin
                    nxt_s.eng = ENG_LAUNCH;
                    if (curSt == ST_C45) begin
                        nxt_s.grpKnown = mmdKnown(curDev);
                        if (curOp == OP_ADDR) begin
                            nxt_s.grpVendor = curSlot[VENDOR_BIT];
                        end
                    end
                end else begin
                    nxt_s.cur = nextSlot(s_ff.cur);
                end
            end
            ENG_LAUNCH: begin
                if (shBusy) begin
                    nxt_s.eng = ENG_WAIT;
                end
            end
            ENG_WAIT: begin
                if (shDone) begin
                    nxt_s.slot[s_ff.cur][SL_DONE] = 1'b1;
                    // Inc-read address step is done by the PHY
                    if (curRead) begin
                        nxt_s.slot[s_ff.cur][SL_DATA_LSB +: 16] =
                            shRd;
                    end
                    nxt_s.cur = nextSlot(s_ff.cur);
                    nxt_s.eng = ENG_SCAN;
                end
            end
        endcase
    end

    // ========================================================
    // State register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_ff <= '0;
            for (int i = 0; i < SLOT_NUM; i++) begin
                s_ff.slot[i] <= SLOT_RST;
            end
            s_ff.eng <= ENG_SCAN;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ========================================================
    // MDC and frame shifter
    ima_mdc_gen u_mdc (
        .mclk(mclk),
        .reset_n(reset_n),
        .fastSel(s_ff.speedSel),
        .mdc(mdc),
        .riseEn(riseEn),
        .fallEn(fallEn)
    );

    ima_mdio_shift u_shift (
        .mclk(mclk),
        .reset_n(reset_n),
        .riseEn(riseEn),
        .fallEn(fallEn),
        .start(shStart),
        .frame(curFrame),
        .turnRead(curRead),
        .mdioIn(s_ff.mdioSync[1]),
        .busy(shBusy),
        .done(shDone),
        .rdData(shRd),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe)
    );

    assign prdata = s_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = access && !hit;
    assign phyPowerDown = s_ff.pwrDown;
endmodule

//--- ima_mdio_engine_asserts.sv
/*
 Port checker of the management engine: APB answers, MDC timing and
 MDIO frame shape.
 Assumes it is bound to ima_mdio_engine and sees only its ports.
*/
`timescale 1ns/100ps
module ima_mdio_engine_chk import ima_pkg::*; (
    input wire logic mclk, // system clock
    input wire logic reset_n, // sync reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic mdc, // management clock
    input wire logic mdioOut, // MDIO drive value
    input wire logic mdioOe, // MDIO drive enable
    input wire logic strapPowerDown, // power-down strap
    input wire logic phyPowerDown // power-down state
);
    logic mdcPrev_ff;
    logic [5:0] mdcCnt_ff;
    logic [11:0] oeCnt_ff;
    logic mapped;
    // ========================================================
    // Helpers
    assign mapped = paddr <= 8'h28 && paddr[1:0] == 2'h0;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mdcPrev_ff <= 1'b0;
            mdcCnt_ff <= 6'h0;
            oeCnt_ff <= 12'h0;
        end else begin
            mdcPrev_ff <= mdc;
            mdcCnt_ff <= (mdc != mdcPrev_ff) ? 6'h1 : mdcCnt_ff + 6'h1;
            oeCnt_ff <= mdioOe ? oeCnt_ff + 12'h1 : 12'h0;
        end
    end
    // ========================================================
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_zeroWait; psel && penable |-> pready; endproperty
    a_zeroWait: assert property (p_zeroWait) else $error("ready low");
    property p_errBad; psel && penable && !mapped |-> pslverr; endproperty
    a_errBad: assert property (p_errBad) else $error("no error");
    property p_errOk; psel && penable && mapped |-> !pslverr; endproperty
    a_errOk: assert property (p_errOk) else $error("false error");
    property p_errData; pslverr |-> prdata == 32'h0; endproperty
    a_errData: assert property (p_errData) else $error("error data");
    property p_frameOpen;
        $rose(mdioOe) |-> (!mdc && mdioOut) ##1 mdioOut [*7];
    endproperty
    a_frameOpen: assert property (p_frameOpen)
        else $error("bad start");
    property p_outStable;
        mdioOe && mdc && mdcPrev_ff |-> mdioOut == $past(mdioOut);
    endproperty
    a_outStable: assert property (p_outStable)
        else $error("out moved");
    property p_mdcHalf; mdc != mdcPrev_ff |-> mdcCnt_ff >= 6'hF; endproperty
    a_mdcHalf: assert property (p_mdcHalf) else $error("mdc fast");
    property p_oeLen;
        $fell(mdioOe) |-> oeCnt_ff inside {[1370:1390], [1905:1925],
            [2290:2310], [3170:3205]};
    endproperty
    a_oeLen: assert property (p_oeLen) else $error("frame length");
    property p_strap;
        $rose(reset_n) |-> ##[3:6] phyPowerDown == strapPowerDown;
    endproperty
    a_strap: assert property (p_strap) else $error("strap lost");
endmodule
bind ima_mdio_engine ima_mdio_engine_chk i_chk (.mclk(mclk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mdc(mdc),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .strapPowerDown(strapPowerDown),
    .phyPowerDown(phyPowerDown));

//--- ima_phy_model.sv
/*
 Behavioural PHY management side: decodes Clause 22/45 frames on MDC
 and answers reads after turnaround.
 Assumes the bench resolves the shared line with a pull-up.
*/
`timescale 1ns/100ps
module ima_phy_model import ima_pkg::*; (
    input wire logic mdc, // management clock
    input wire logic line, // resolved MDIO level
    output logic phyOe, // 1 while driving the line
    output logic phyOut // drive value
);
    logic [15:0] mem [logic [20:0]];
    logic [15:0] cur [32] = '{default: 16'h0};
    logic [15:0] sh, rdat;
    logic [12:0] hdr;
    logic [20:0] key;
    logic inF = 1'b0, rd = 1'b0, mine = 1'b0;
    int ones = 0, idx = 0;
    initial begin
        phyOe = 1'b0;
        phyOut = 1'b0;
    end
    always @(posedge mdc) begin
        if (!inF) begin
            if (!line && ones >= 32) begin
                inF = 1'b1;
                idx = 33;
            end
            ones = line ? ones + 1 : 0;
        end else begin
            sh = {sh[14:0], line};
            if (idx == 45) begin
                hdr = sh[12:0];
                mine = hdr[9:5] == 5'h01;
                rd = mine && hdr[11];
                key = hdr[12] ? 21'(hdr[4:0]) : {hdr[4:0], cur[hdr[4:0]]};
                rdat = mem.exists(key) ? mem[key] : key[15:0] ^ 16'h5A3C;
                if (!hdr[12] && hdr[11:10] == OP_INCRD) begin
                    cur[hdr[4:0]]++;
                end
            end
            if (idx == 63) begin
                if (mine && !rd && !hdr[12] && hdr[11:10] == OP_ADDR) begin
                    cur[hdr[4:0]] = sh;
                end else if (mine && !rd && hdr[11:10] == OP_WRITE) begin
                    mem[key] = sh;
                end
                inF = 1'b0;
                ones = 0;
            end
            idx++;
        end
    end
    // Change on the fall so each bit holds long past the next rise
    always @(negedge mdc) begin
        phyOe <= inF && rd && idx >= 47;
        phyOut <= (idx >= 48 && idx <= 63) ? rdat[63 - idx] : 1'b0;
    end
endmodule

//--- ima_mdio_engine_tb.sv
/*
 Self-checking bench of the management engine over APB, with a PHY
 model on the MDIO pins.
 Assumes the engine answers APB with no wait states or later.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
    failCount++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); \
    end end
module ima_mdio_engine_tb import ima_pkg::*;;
    logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic linkUp = 1, pageRx = 0, strap = 1;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic pready, pslverr, mdc, mdioOut, mdioOe, phyPd, phyOe, phyOut;
    logic line, err;
    logic [15:0] d;
    logic [4:0] gDev [5] = '{MMD_PMA, MMD_PCS, MMD_AN, MMD_VEND1, 5'h02};
    int failCount = 0, compares = 0, cyc = 0;
    time t0, per;
    assign line = mdioOe ? mdioOut : phyOe ? phyOut : 1'b1;
    ima_mdio_engine i_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mdc(mdc), .mdioIn(line), .mdioOut(mdioOut),
        .mdioOe(mdioOe), .linkUpPin(linkUp), .pageRxPin(pageRx),
        .strapPowerDown(strap), .phyPowerDown(phyPd));
    ima_phy_model i_phy (.mdc(mdc), .line(line), .phyOe(phyOe),
        .phyOut(phyOut));
    // ========================================================
    // Tasks
    task endSim();
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task waitSlot(input int s);
        do apb(1'b0, 8'(4 * s), 32'h0); while (rdv[SL_DONE] !== 1'b1);
    endtask
    task mper();
        repeat (2) @(posedge mdc);
        t0 = $time;
        @(posedge mdc);
        per = $time - t0;
    endtask
    task blip();
        linkUp <= 1'b0;
        repeat (6) @(posedge mclk);
        linkUp <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask
    function logic [31:0] sl(logic [1:0] st, op, logic [4:0] dv,
            logic [15:0] v);
        return {2'b00, st, op, 5'h01, dv, v};
    endfunction
    // ========================================================
    // Clock, timeout, tests
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            failCount++;
            $display("ERROR %0t: timeout", $time);
            endSim();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < SLOT_NUM; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rdv, SLOT_RST)
        end
        apb(1'b0, OFF_CFG, 32'h0);
        `CHK(rdv[1:0], 2'b10)
        apb(1'b0, 8'h2C, 32'h0);
        `CHK({err, rdv}, {1'b1, 32'h0})
        apb(1'b1, 8'h06, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rdv, SLOT_RST)
        apb(1'b0, OFF_LINK, 32'h0);
        `CHK(rdv[1:0], 2'b01)
        mper();
        `CHK(per, 400)
        apb(1'b1, OFF_CFG, 32'h0);
        $display("reset test done");
        // Whole queue loaded before any poll
        apb(1'b1, 8'h00, sl(ST_C45, OP_ADDR, MMD_PCS, 16'h8010));
        apb(1'b1, 8'h04, sl(ST_C45, OP_WRITE, MMD_PCS, 16'h1234));
        apb(1'b1, 8'h08, sl(ST_C45, OP_ADDR, MMD_PCS, 16'h8010));
        apb(1'b1, 8'h0C, sl(ST_C45, OP_READ, MMD_PCS, 16'h0));
        apb(1'b1, 8'h10, sl(ST_C45, OP_ADDR, MMD_AN, 16'h0100));
        for (int i = 5; i < 8; i++) begin
            apb(1'b1, 8'(4 * i), sl(ST_C45, OP_INCRD, MMD_AN, 16'h0));
        end
        waitSlot(7);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rdv[SL_DONE], 1'b1)
        end
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rdv[15:0], 16'h1234)
        for (int i = 5; i < 8; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rdv[15:0], (16'h00FB + 16'(i)) ^ 16'h5A3C)
        end
        $display("queue test done");
        apb(1'b1, OFF_CFG, 32'h1);
        mper();
        `CHK(per, 240)
        for (int i = 0; i < 5; i++) begin
            d = i[0] ? 16'h8000 : 16'h7FFF;
            apb(1'b1, 8'h00, sl(ST_C45, OP_ADDR, gDev[i], d));
            waitSlot(0);
            apb(1'b0, OFF_GRP, 32'h0);
            `CHK(rdv[1:0], {d[15], i < 4})
        end
        $display("group test done");
        apb(1'b1, 8'h00, sl(ST_C22, OP_WRITE, 5'h0A, 16'hBEEF));
        apb(1'b1, 8'h04, sl(ST_C22, OP_READ, 5'h0A, 16'h0));
        waitSlot(1);
        `CHK(rdv[15:0], 16'hBEEF)
        $display("clause22 test done");
        blip();
        apb(1'b0, OFF_LINK, 32'h0);
        `CHK(rdv[0], 1'b0)
        apb(1'b0, OFF_LINK, 32'h0);
        `CHK(rdv[0], 1'b1)
        pageRx <= 1'b1;
        blip();
        apb(1'b0, OFF_LINK, 32'h0);
        `CHK(rdv[1:0], 2'b10)
        apb(1'b0, OFF_LINK, 32'h0);
        `CHK(rdv[1:0], 2'b11)
        blip();
        apb(1'b1, OFF_CFG, 32'h3);
        apb(1'b0, OFF_LINK, 32'h0);
        `CHK({phyPd, rdv[0]}, 2'b11)
        $display("latch test done");
        endSim();
    end
endmodule
